// ==== rtl/dchp_pkg.sv ====
/*
   Shared constants and carrier types of the dual channel host bus port.
   Assumes a single 20 MHz clock and that the users write dchp_pkg::name.
*/
package dchp_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int NUM_CHAN = 2;
   localparam int CHAN_A = 0;
   localparam int CHAN_B = 1;
   localparam logic PICK_CHAN_A = 1'b1;
   localparam logic [ADDR_W-1:0] REG_IDX_ALT_FUNC = 3'h2;
   localparam logic [ADDR_W-1:0] REG_IDX_MODEM_CTRL = 3'h4;
   localparam int ALT_FUNC_BCAST_BIT = 0;
   localparam int MODEM_CTRL_IR_BIT = 6;
   localparam logic SERIAL_IDLE_STD = 1'b1;
   localparam logic SERIAL_IDLE_IR = 1'b0;
   localparam logic TX_READY_N_RST = 1'b1;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   typedef struct packed {
      logic chip_select_n;
      logic channel_pick;
      logic read_strobe_n;
      logic write_strobe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } dchp_pins_t;

   localparam dchp_pins_t PINS_IDLE = '{
      chip_select_n: 1'b1,
      channel_pick: 1'b0,
      read_strobe_n: 1'b1,
      write_strobe_n: 1'b1,
      addr: 3'h0,
      data: 8'h00
   };

   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } dchp_access_t;
endpackage

// ==== rtl/dchp_regbank.sv ====
/*
   Register bank of one channel: eight bytes, registered read data.
   Assumes its caller issues one-cycle read and write enables.
*/
`timescale 1ns/100ps
module dchp_regbank #(
   parameter int AW = dchp_pkg::ADDR_W,
   parameter int DW = dchp_pkg::DATA_W
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wr_en_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic rd_en_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [DW-1:0] rd_data_o
);
   logic [DW-1:0] mem [2**AW];
   logic [DW-1:0] next_rd_data;

   always_comb begin
      next_rd_data = rd_data_o;
      if (rd_en_i) begin
         next_rd_data = mem[rd_addr_i];
      end
   end

   // The array has no reset; only the read register is a control state.
   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
      end else begin
         rd_data_o <= next_rd_data;
      end
   end
endmodule

// ==== rtl/dchp_port.sv ====
/*
   Host bus port of a dual channel serial controller: strobe decoding,
   channel steering, broadcast writes, per channel status pins and the
   transmit pin idle level. Assumes the serial engines sit on clk_i and
   supply interrupt, transmit space, busy and bit levels.
   Assumes too that the host holds address, channel pick and write data
   steady from before a strobe falls until after it rises, and keeps
   each strobe low and each gap between accesses at least four clocks.
*/
// Function
// RULE1: Read strobe fall starts an internal read of the addressed register.
// RULE2: Device drives the read byte; host samples it at read strobe rise.
// RULE3: Write starts on write strobe fall; data is stored at its rise.
// RULE4: Channel pick counts only while chip select is low.
// RULE5: Channel pick low selects channel B, high selects channel A.
// RULE6: Broadcast bit ignores channel pick; one write reaches both channels.
// RULE7: Each channel has an active high interrupt output.
// RULE8: Each channel has an active low transmitter ready output.
// RULE9: Standard mode holds the transmit pin high in reset and idle.
// RULE10: Infrared mode encodes transmit data and idles the pin low.
// RULE11: Three address lines select a register of the chosen channel.
// RULE12: Eight bit data bus driven by device only during reads.
// RULE13: Chip select high ignores both strobes and releases the data bus.
`timescale 1ns/100ps
module dchp_port (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic chip_select_n_i,
   input wire logic channel_pick_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_n_i,
   input wire logic [dchp_pkg::ADDR_W-1:0] addr_i,
   input wire logic [dchp_pkg::DATA_W-1:0] data_i,
   output logic [dchp_pkg::DATA_W-1:0] data_o,
   output logic data_oe_o,
   input wire logic [dchp_pkg::NUM_CHAN-1:0] chan_irq_req_i,
   input wire logic [dchp_pkg::NUM_CHAN-1:0] chan_tx_space_i,
   input wire logic [dchp_pkg::NUM_CHAN-1:0] chan_tx_busy_i,
   input wire logic [dchp_pkg::NUM_CHAN-1:0] chan_tx_bit_i,
   output logic irq_chan_a_o,
   output logic irq_chan_b_o,
   output logic tx_ready_chan_a_n_o,
   output logic tx_ready_chan_b_n_o,
   output logic serial_out_chan_a_o,
   output logic serial_out_chan_b_o,
   output dchp_pkg::dchp_access_t access_a_o,
   output dchp_pkg::dchp_access_t access_b_o
);
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_RD_WAIT,
      ST_READ,
      ST_WRITE
   } dchp_state_t;

   localparam int NC = dchp_pkg::NUM_CHAN;
   localparam int CA = dchp_pkg::CHAN_A;
   localparam int CB = dchp_pkg::CHAN_B;

   dchp_pkg::dchp_pins_t pins_in;
   dchp_pkg::dchp_pins_t sync1;
   dchp_pkg::dchp_pins_t sync2;
   dchp_pkg::dchp_pins_t prev;
   dchp_pkg::dchp_pins_t next_sync1;
   dchp_pkg::dchp_pins_t next_sync2;
   dchp_pkg::dchp_pins_t next_prev;

   dchp_state_t state;
   dchp_state_t next_state;
   logic chan_a;
   logic next_chan_a;
   logic bcast;
   logic next_bcast;
   logic [dchp_pkg::ADDR_W-1:0] addr;
   logic [dchp_pkg::ADDR_W-1:0] next_addr;
   logic [dchp_pkg::DATA_W-1:0] wdata;
   logic [dchp_pkg::DATA_W-1:0] next_wdata;
   logic [NC-1:0] wr_pulse;
   logic [NC-1:0] next_wr_pulse;
   logic [NC-1:0] rd_pulse;
   logic [NC-1:0] next_rd_pulse;
   logic [dchp_pkg::DATA_W-1:0] next_data;
   logic next_oe;
   logic bank_re;
   logic [dchp_pkg::DATA_W-1:0] bank_rd [NC];

   logic [NC-1:0] ir_mode;
   logic [NC-1:0] next_ir_mode;
   logic [NC-1:0] alt_bcast;
   logic [NC-1:0] next_alt_bcast;
   logic [NC-1:0] irq;
   logic [NC-1:0] next_irq;
   logic [NC-1:0] txrdy_n;
   logic [NC-1:0] next_txrdy_n;
   logic [NC-1:0] ser;
   logic [NC-1:0] next_ser;

   logic selected;
   logic rd_fall;
   logic rd_rise;
   logic wr_fall;
   logic wr_rise;

   assign pins_in = '{
      chip_select_n: chip_select_n_i,
      channel_pick: channel_pick_i,
      read_strobe_n: read_strobe_n_i,
      write_strobe_n: write_strobe_n_i,
      addr: addr_i,
      data: data_i
   };

   // Data is synchronised with the strobes, so both settle on the same edge.
   always_comb begin
      next_sync1 = pins_in;
      next_sync2 = sync1;
      next_prev = sync2;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sync1 <= dchp_pkg::PINS_IDLE;
         sync2 <= dchp_pkg::PINS_IDLE;
         prev <= dchp_pkg::PINS_IDLE;
      end else begin
         sync1 <= next_sync1;
         sync2 <= next_sync2;
         prev <= next_prev;
      end
   end

   assign selected = !sync2.chip_select_n; // [RULE4] [RULE13]
   assign rd_fall = prev.read_strobe_n && !sync2.read_strobe_n;
   assign rd_rise = !prev.read_strobe_n && sync2.read_strobe_n;
   assign wr_fall = prev.write_strobe_n && !sync2.write_strobe_n;
   assign wr_rise = !prev.write_strobe_n && sync2.write_strobe_n;

   // One access at a time: edges that arrive while busy are dropped.
   always_comb begin
      next_state = state;
      next_chan_a = chan_a;
      next_bcast = bcast;
      next_addr = addr;
      next_wdata = wdata;
      next_wr_pulse = '0;
      next_rd_pulse = '0;
      next_data = data_o;
      next_oe = 1'b0;
      bank_re = 1'b0;
      case (state)
         ST_IDLE: begin
            if (selected && rd_fall && sync2.write_strobe_n) begin
               // [RULE1] [RULE5] [RULE11]
               next_chan_a = sync2.channel_pick == dchp_pkg::PICK_CHAN_A;
               next_addr = sync2.addr;
               bank_re = 1'b1;
               next_rd_pulse[CA] = next_chan_a;
               next_rd_pulse[CB] = !next_chan_a;
               next_state = ST_RD_WAIT;
            end else if (selected && wr_fall) begin
               // [RULE3] [RULE5] [RULE6] [RULE11]
               next_chan_a = sync2.channel_pick == dchp_pkg::PICK_CHAN_A;
               next_addr = sync2.addr;
               next_bcast = |alt_bcast;
               next_state = ST_WRITE;
            end
         end
         ST_RD_WAIT: begin
            // One cycle lets the bank's registered read data settle.
            next_data = chan_a ? bank_rd[CA] : bank_rd[CB];
            next_oe = selected; // [RULE2] [RULE12]
            next_state = selected ? ST_READ : ST_IDLE;
         end
         ST_READ: begin
            next_oe = selected && !sync2.read_strobe_n; // [RULE2] [RULE13]
            if (!selected || rd_rise) begin
               next_state = ST_IDLE;
            end
         end
         ST_WRITE: begin
            if (!selected) begin
               // A chip select that rises mid-write drops the byte whole.
               next_state = ST_IDLE; // [RULE13]
            end else if (wr_rise) begin
               next_wdata = sync2.data; // [RULE3] [RULE12]
               next_wr_pulse[CA] = bcast || chan_a; // [RULE6]
               next_wr_pulse[CB] = bcast || !chan_a; // [RULE6]
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         chan_a <= 1'b0;
         bcast <= 1'b0;
         addr <= '0;
         wdata <= dchp_pkg::DATA_RST;
         wr_pulse <= '0;
         rd_pulse <= '0;
         data_o <= dchp_pkg::DATA_RST;
         data_oe_o <= 1'b0;
      end else begin
         state <= next_state;
         chan_a <= next_chan_a;
         bcast <= next_bcast;
         addr <= next_addr;
         wdata <= next_wdata;
         wr_pulse <= next_wr_pulse;
         rd_pulse <= next_rd_pulse;
         data_o <= next_data;
         data_oe_o <= next_oe;
      end
   end

   // Both banks read on every read access; only the picked byte reaches the pins.
   for (genvar c = 0; c < NC; c++) begin : g_bank
      dchp_regbank u_bank (
         .clk_i(clk_i),
         .rst_n_i(rst_n_i),
         .wr_en_i(wr_pulse[c]),
         .wr_addr_i(addr),
         .wr_data_i(wdata),
         .rd_en_i(bank_re),
         .rd_addr_i(sync2.addr),
         .rd_data_o(bank_rd[c])
      );
   end

   // Each channel keeps its own mode bits; broadcast follows either copy.
   always_comb begin
      next_ir_mode = ir_mode;
      next_alt_bcast = alt_bcast;
      for (int c = 0; c < NC; c++) begin
         if (wr_pulse[c] && addr == dchp_pkg::REG_IDX_MODEM_CTRL) begin
            next_ir_mode[c] = wdata[dchp_pkg::MODEM_CTRL_IR_BIT];
         end
         if (wr_pulse[c] && addr == dchp_pkg::REG_IDX_ALT_FUNC) begin
            next_alt_bcast[c] = wdata[dchp_pkg::ALT_FUNC_BCAST_BIT];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ir_mode <= '0;
         alt_bcast <= '0;
      end else begin
         ir_mode <= next_ir_mode;
         alt_bcast <= next_alt_bcast;
      end
   end

   // Status pins lag the engines by one clock so each leaves a flip-flop.
   always_comb begin
      next_ser = ser;
      next_irq = chan_irq_req_i; // [RULE7]
      next_txrdy_n = ~chan_tx_space_i; // [RULE8]
      for (int c = 0; c < NC; c++) begin
         if (ir_mode[c]) begin
            // Zero bits become high pulses; the pin rests low. [RULE10]
            next_ser[c] = chan_tx_busy_i[c] ? !chan_tx_bit_i[c]
               : dchp_pkg::SERIAL_IDLE_IR;
         end else begin
            // [RULE9]
            next_ser[c] = chan_tx_busy_i[c] ? chan_tx_bit_i[c]
                                            : dchp_pkg::SERIAL_IDLE_STD;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         irq <= '0;
         txrdy_n <= {NC{dchp_pkg::TX_READY_N_RST}};
         ser <= {NC{dchp_pkg::SERIAL_IDLE_STD}}; // [RULE9]
      end else begin
         irq <= next_irq;
         txrdy_n <= next_txrdy_n;
         ser <= next_ser;
      end
   end

   assign irq_chan_a_o = irq[CA];
   assign irq_chan_b_o = irq[CB];
   assign tx_ready_chan_a_n_o = txrdy_n[CA];
   assign tx_ready_chan_b_n_o = txrdy_n[CB];
   assign serial_out_chan_a_o = ser[CA];
   assign serial_out_chan_b_o = ser[CB];
   assign access_a_o = '{
      rd: rd_pulse[CA],
      wr: wr_pulse[CA],
      addr: addr,
      data: wdata
   };
   assign access_b_o = '{
      rd: rd_pulse[CB],
      wr: wr_pulse[CB],
      addr: addr,
      data: wdata
   };
endmodule

// ==== test/dchp_port_chk.sv ====
/* Pin level checks of the host bus port.
   Assumes a bind onto dchp_port and its single clock. */
`timescale 1ns/100ps
module dchp_port_chk (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic chip_select_n_i,
   input wire logic channel_pick_i,
   input wire logic read_strobe_n_i,
   input wire logic [2:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic data_oe_o,
   input wire logic [1:0] chan_irq_req_i,
   input wire logic [1:0] chan_tx_space_i,
   input wire logic irq_chan_a_o,
   input wire logic tx_ready_chan_a_n_o,
   input wire logic serial_out_chan_a_o,
   input wire dchp_pkg::dchp_access_t access_a_o,
   input wire dchp_pkg::dchp_access_t access_b_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   irq_lag_a: assert property (
      $past(rst_n_i) |-> irq_chan_a_o == $past(chan_irq_req_i[0]))
      else $error("irq lag");
   ready_lag_a: assert property (
      $past(rst_n_i) |-> tx_ready_chan_a_n_o == !$past(chan_tx_space_i[0]))
      else $error("ready lag");
   tx_reset_a: assert property (
      !$past(rst_n_i) |-> serial_out_chan_a_o)
      else $error("tx idle");
   bus_free_a: assert property (
      chip_select_n_i [*5] |-> !data_oe_o)
      else $error("bus held");
   oe_cause_a: assert property (
      $rose(data_oe_o) |-> $past(read_strobe_n_i, 3) == 1'b0
      && $past(chip_select_n_i, 3) == 1'b0) else $error("oe cause");
   route_a_a: assert property (
      access_a_o.rd |-> $past(channel_pick_i, 2))
      else $error("route");
   route_b_a: assert property (
      access_b_o.rd |-> !$past(channel_pick_i, 2))
      else $error("route b");
   wr_pulse_a: assert property (
      access_a_o.wr |=> !access_a_o.wr)
      else $error("wr width");
   wr_data_a: assert property (
      access_a_o.wr |-> access_a_o.data == $past(data_i, 2)
      && access_a_o.addr == $past(addr_i, 2)) else $error("wr data");
endmodule
bind dchp_port dchp_port_chk chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .chip_select_n_i(chip_select_n_i), .channel_pick_i(channel_pick_i),
   .read_strobe_n_i(read_strobe_n_i), .addr_i(addr_i), .data_i(data_i),
   .data_oe_o(data_oe_o), .chan_irq_req_i(chan_irq_req_i),
   .chan_tx_space_i(chan_tx_space_i), .irq_chan_a_o(irq_chan_a_o),
   .tx_ready_chan_a_n_o(tx_ready_chan_a_n_o),
   .serial_out_chan_a_o(serial_out_chan_a_o), .access_a_o(access_a_o),
   .access_b_o(access_b_o));

// ==== test/dchp_host.sv ====
/* Host processor model on the port's parallel bus pins.
   Assumes the port answers a read within four clocks. */
`timescale 1ns/100ps
module dchp_host (
   input wire logic clk_i,
   input wire logic [7:0] data_i,
   input wire logic data_oe_i,
   output dchp_pkg::dchp_pins_t pins_o,
   output logic [7:0] bus_o
);
   logic drv = 1'b0;
   logic [7:0] hd = 8'h00;
   logic [7:0] pat = 8'h5A;
   initial pins_o = dchp_pkg::PINS_IDLE;
   // A free bus toggles between 5A and A5, so an undriven read fails unless the byte expected is one of those two.
   always @(posedge clk_i) pat <= ~pat;
   assign bus_o = data_oe_i ? data_i : (drv ? hd : pat);
   task automatic xfer(input logic cs_n, wr, pick, input logic [2:0] a,
         input logic [7:0] d, output logic [7:0] q, output logic seen);
      @(posedge clk_i);
      #1 pins_o.chip_select_n = cs_n;
      pins_o.channel_pick = pick;
      pins_o.addr = a;
      drv = wr;
      hd = d;
      @(posedge clk_i);
      #1 pins_o.write_strobe_n = !wr;
      pins_o.read_strobe_n = wr;
      repeat (5) @(posedge clk_i);
      #1 q = bus_o;
      seen = data_oe_i;
      @(posedge clk_i);
      #1 pins_o.read_strobe_n = 1'b1;
      pins_o.write_strobe_n = 1'b1;
      // Chip select and data stay put past the rise.
      repeat (4) @(posedge clk_i);
      #1 pins_o = dchp_pkg::PINS_IDLE;
      drv = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
endmodule

// ==== test/dchp_port_bench.sv ====
/* Self-checking bench of the host bus port.
   Assumes the host model and the checker are compiled first. */
`timescale 1ns/100ps
module dchp_port_bench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic oe, irq_a, irq_b, rdy_a, rdy_b, ser_a, ser_b, s;
   logic bcast = 1'b0;
   logic [1:0] irq_req = 2'h0, space = 2'h0, busy = 2'h0, tbit = 2'h0;
   logic [7:0] dout, bus, q, outs;
   logic [7:0] mem [2][8];
   dchp_pkg::dchp_pins_t pins;
   int mismatches = 0;
   int num_checks = 0;
   always #25 clk = ~clk;
   assign outs = {1'b0, oe, ser_b, ser_a, rdy_b, rdy_a, irq_b, irq_a};
   dchp_host host (.clk_i(clk), .data_i(dout), .data_oe_i(oe),
      .pins_o(pins), .bus_o(bus));
   dchp_port DUT (.clk_i(clk), .rst_n_i(rst_n),
      .chip_select_n_i(pins.chip_select_n),
      .channel_pick_i(pins.channel_pick), .addr_i(pins.addr),
      .read_strobe_n_i(pins.read_strobe_n), .data_i(bus),
      .write_strobe_n_i(pins.write_strobe_n), .data_o(dout),
      .data_oe_o(oe), .chan_irq_req_i(irq_req), .chan_tx_space_i(space),
      .chan_tx_busy_i(busy), .chan_tx_bit_i(tbit), .irq_chan_a_o(irq_a),
      .irq_chan_b_o(irq_b), .tx_ready_chan_a_n_o(rdy_a),
      .tx_ready_chan_b_n_o(rdy_b), .serial_out_chan_a_o(ser_a),
      .serial_out_chan_b_o(ser_b), .access_a_o(), .access_b_o());
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic pick, input logic [2:0] a,
         input logic [7:0] d);
      host.xfer(1'b0, 1'b1, pick, a, d, q, s);
      for (int c = 0; c < 2; c++)
         if (bcast || c[0] != pick)
            mem[c][a] = d;
      if (a == dchp_pkg::REG_IDX_ALT_FUNC)
         bcast = d[dchp_pkg::ALT_FUNC_BCAST_BIT];
   endtask
   task automatic rd(input logic pick, input logic [2:0] a);
      host.xfer(1'b0, 1'b0, pick, a, 8'h00, q, s);
      chk(q, mem[!pick][a]);
   endtask
   task automatic t_reset;
      rst_n = 1'b0;
      bcast = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk(outs, 8'h3C);
      rst_n = 1'b1;
   endtask
   task automatic t_status;
      for (int i = 0; i < 4; i++) begin
         irq_req = i[1:0];
         space = ~i[1:0];
         repeat (2) @(posedge clk);
         #1 chk({6'h00, irq_b, irq_a}, i[7:0]);
         chk({6'h00, rdy_b, rdy_a}, i[7:0]);
      end
   endtask
   task automatic t_rw;
      for (int a = 0; a < 16; a++)
         wr(a[3], a[2:0], {a[2:0], a[3], 4'hA});
      for (int a = 0; a < 16; a++)
         rd(a[0], a[3:1]);
   endtask
   task automatic t_cs;
      host.xfer(1'b1, 1'b1, 1'b1, 3'h0, 8'hFF, q, s);
      host.xfer(1'b1, 1'b0, 1'b1, 3'h0, 8'h00, q, s);
      chk({7'h00, s}, 8'h00);
      rd(1'b1, 3'h0);
   endtask
   task automatic t_bcast;
      wr(1'b1, dchp_pkg::REG_IDX_ALT_FUNC, 8'h01);
      wr(1'b0, 3'h1, 8'h5A);
      rd(1'b1, 3'h1);
      rd(1'b0, 3'h1);
      wr(1'b0, dchp_pkg::REG_IDX_ALT_FUNC, 8'h00);
      wr(1'b1, 3'h3, 8'hC3);
      rd(1'b0, 3'h3);
   endtask
   task automatic step(input logic [1:0] b, t, input logic [7:0] e);
      busy = b;
      tbit = t;
      repeat (2) @(posedge clk);
      #1 chk({6'h00, ser_b, ser_a}, e);
   endtask
   task automatic t_ir;
      wr(1'b1, dchp_pkg::REG_IDX_MODEM_CTRL, 8'h40);
      step(2'h0, 2'h0, 8'h02);
      step(2'h1, 2'h0, 8'h03);
      step(2'h1, 2'h1, 8'h02);
      wr(1'b0, dchp_pkg::REG_IDX_MODEM_CTRL, 8'h40);
      step(2'h2, 2'h0, 8'h02);
      step(2'h0, 2'h0, 8'h00);
      wr(1'b1, dchp_pkg::REG_IDX_MODEM_CTRL, 8'h00);
      wr(1'b0, dchp_pkg::REG_IDX_MODEM_CTRL, 8'h00);
      step(2'h2, 2'h0, 8'h01);
      step(2'h1, 2'h1, 8'h03);
      step(2'h1, 2'h0, 8'h02);
      step(2'h0, 2'h0, 8'h03);
   endtask
   initial begin
      t_reset();
      t_status();
      t_rw();
      t_cs();
      t_bcast();
      t_ir();
      t_reset();
      results();
   end
   // About 730 clocks are needed; the margin allows for slow answers.
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      results();
   end
endmodule
